/* hdl/ipf_pkg.sv */
package ipf_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_P1_OUT_LATCH = 16'hffd1;
  localparam logic [15:0] IDX_P1_DIR_CTRL  = 16'hffe1;
  localparam logic [15:0] IDX_P1_PIN_MODE  = 16'hffeb;
  localparam logic [15:0] IDX_WAVE_MODE    = 16'hffee;
  localparam logic [15:0] IDX_P0_LEVELS    = 16'hffd0;
  localparam logic [15:0] IDX_P0_ANALOG    = 16'hffef;
  localparam logic [15:0] IDX_INT_STATUS   = 16'hfff0;
  localparam logic [15:0] IDX_INT_MASK     = 16'hfff1;

  // Values after reset
  localparam logic [7:0] RST_P0_ANALOG = 8'h00;
  localparam logic [7:0] RST_P1_MODE   = 8'h0c;
  localparam logic [7:0] RST_P1_DIR    = 8'hcc;
  localparam logic [7:0] RST_P1_LATCH  = 8'h0c;
  localparam logic [7:0] RST_WAVE_MODE = 8'h0f;

  // Field layouts
  localparam logic [7:0] P1_MODE_RSV   = 8'h0c;
  localparam logic [7:0] P1_DIR_RSV    = 8'hcc;
  localparam logic [7:0] P1_GEN_PINS   = 8'h33;
  localparam logic [7:0] P1_IN_ONLY    = 8'hc0;
  localparam logic [7:0] WAVE_MODE_RSV = 8'h0f;
  localparam int NC_BIT     = 7;
  localparam int EVENT_BIT  = 6;
  localparam int EXT_INT5_BIT = 5;
  localparam int EXT_INT4_BIT = 4;
  localparam int EXT_INT1_BIT = 1;
  localparam int EXT_INT0_BIT = 0;
  localparam int WAVE_SEL   = 7;
  localparam int WAVE_ON    = 6;
  localparam int NUM_IRQ    = 4;

  // Noise canceller sampling interval in states (clock cycles)
  localparam int NC_SAMPLE_STATES = 256;

  typedef enum logic [2:0] {
    PWR_ACTIVE,
    PWR_SLEEP,
    PWR_STANDBY,
    PWR_WATCH,
    PWR_SUBACTIVE
  } ipf_pwr_e;

  typedef enum logic {
    BUS_IDLE,
    BUS_ACK
  } ipf_bus_e;

  // Drive of the port-1 pads
  typedef struct packed {
    logic [7:0] dout;
    logic [7:0] oe;
  } ipf_p1drv_s;

endpackage

/* hdl/ipf_noise_cancel.sv */
`timescale 1ns/1ps
`default_nettype none
module ipf_noise_cancel #(
  parameter int unsigned DIV = ipf_pkg::NC_SAMPLE_STATES
) (
  input  wire logic CORE_CLK,
  input  wire logic RST_B,
  input  wire logic nc_enable,
  input  wire logic level_in,
  output var  logic level_out
);
  import ipf_pkg::*;

  localparam int CW = $clog2(DIV);

  initial
  begin
    if (DIV < 2)
    begin
      $error("ipf_noise_cancel: DIV must be at least 2");
    end
  end

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic          smp_q;
  logic          smp_d;
  logic          out_q;
  logic          out_d;
  logic          strobe;

  // Sampling strobe once per DIV states; kept running so the phase is free
  always_comb
  begin
    strobe = (cnt_q == CW'(DIV - 1));
    cnt_d  = strobe ? '0 : cnt_q + 1'b1;
    smp_d  = smp_q;
    out_d  = out_q;
    if (!nc_enable)
    begin
      out_d = level_in;
      smp_d = level_in;
    end
    else if (strobe)
    begin
      smp_d = level_in;
      if (level_in == smp_q)
      begin
        out_d = level_in;
      end
    end
  end

  // Idle level of the active-low interrupt input is high
  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      cnt_q <= '0;
      smp_q <= 1'b1;
      out_q <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_d;
      smp_q <= smp_d;
      out_q <= out_d;
    end
  end

  assign level_out = out_q;

  nc_glitch_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    nc_enable && strobe && (level_in != smp_q) |=> $stable(out_q))
    else $error("noise canceller passed a mismatching sample");

  nc_agree_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    nc_enable && strobe && (level_in == smp_q) |=> (out_q == $past(level_in)))
    else $error("noise canceller missed two agreeing samples");

  nc_filter_c: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
    nc_enable && strobe && (level_in != out_q));

endmodule
`default_nettype wire

/* hdl/ipf_port_top.sv */
`timescale 1ns/1ps
`default_nettype none
module ipf_port_top #(
  parameter int unsigned NC_DIV = ipf_pkg::NC_SAMPLE_STATES
) (
  input  wire logic               CORE_CLK,
  input  wire logic               RST_B,
  input  wire logic [17:0]        AVS_ADDRESS,
  input  wire logic               AVS_READ,
  input  wire logic               AVS_WRITE,
  input  wire logic [31:0]        AVS_WRITEDATA,
  input  wire logic [3:0]         AVS_BYTEENABLE,
  output var  logic [31:0]        AVS_READDATA,
  output var  logic               AVS_WAITREQUEST,
  input  wire ipf_pkg::ipf_pwr_e  PWR_MODE,
  input  wire logic [7:0]         P0_IN,
  output var  logic [7:0]         P0_BUF_EN,
  output var  logic [7:0]         ANALOG_CH_EN,
  input  wire logic [7:0]         P1_IN,
  output var  logic [7:0]         P1_OUT,
  output var  logic [7:0]         P1_OE,
  input  wire logic               TIMER_WAVE_IN,
  output var  logic               COUNT_IN_N,
  output var  logic [3:0]         EXT_IRQ_N,
  output var  logic               IRQ
);
  import ipf_pkg::*;

  initial
  begin
    if (NC_DIV < 2)
    begin
      $error("ipf_port_top: NC_DIV must be at least 2");
    end
  end

  // Mode bit and pin number of each interrupt line: 0,1,4,5
  localparam int IRQ_PIN [NUM_IRQ] = '{EXT_INT0_BIT, EXT_INT1_BIT, EXT_INT4_BIT, EXT_INT5_BIT};

  ipf_bus_e    bus_q;
  ipf_bus_e    bus_d;
  logic        wait_q;
  logic        wait_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;
  logic [7:0]  asel_q;
  logic [7:0]  asel_d;
  logic [7:0]  pmode_q;
  logic [7:0]  pmode_d;
  logic [7:0]  dir_q;
  logic [7:0]  dir_d;
  logic [7:0]  latch_q;
  logic [7:0]  latch_d;
  logic [7:0]  wmode_q;
  logic [7:0]  wmode_d;
  logic [3:0]  ist_q;
  logic [3:0]  ist_d;
  logic [3:0]  imsk_q;
  logic [3:0]  imsk_d;
  logic        irq_q;
  logic        irq_d;
  logic [15:0] idx;
  logic        wr_lo;
  logic [7:0]  wb;
  logic [7:0]  rd_byte;
  logic [7:0]  p0_rd;
  logic [7:0]  p1_rd;

  logic [7:0]  p0_lvl_q;
  logic [7:0]  p0_lvl_d;
  logic [7:0]  p0_en_q;
  logic [7:0]  p0_en_d;
  logic [7:0]  an_q;
  logic [7:0]  an_d;
  ipf_p1drv_s  drv_q;
  ipf_p1drv_s  drv_d;
  logic        cnt_q;
  logic        cnt_d;
  logic [3:0]  xirq_q;
  logic [3:0]  xirq_d;
  logic [3:0]  xirq_raw;
  logic [3:0]  xirq_evt;
  logic        int0_filt;
  logic        nc_on;
  logic        low_power;
  logic        pins_live;
  logic        wave_sel;

  assign idx   = AVS_ADDRESS[17:2];
  assign wb    = AVS_WRITEDATA[7:0];
  assign wr_lo = (bus_q == BUS_ACK) && AVS_WRITE && AVS_BYTEENABLE[0];

  // Standby, watch and subactive stop the port-0 buffers and the canceller
  assign low_power = (PWR_MODE == PWR_STANDBY) || (PWR_MODE == PWR_WATCH) || (PWR_MODE == PWR_SUBACTIVE);
  assign pins_live = (PWR_MODE == PWR_ACTIVE) || (PWR_MODE == PWR_SLEEP);

  assign p0_rd = p0_lvl_q | asel_q;

  // latch for outputs, pin for inputs; peripheral pins read the same way
  assign p1_rd = (dir_q & latch_q & P1_GEN_PINS) | (~dir_q & P1_IN & P1_GEN_PINS) | (P1_IN & P1_IN_ONLY) | P1_MODE_RSV;

  // Read multiplexer; unmapped and write-only registers read zero
  always_comb
  begin
    if (idx == IDX_P0_LEVELS)
    begin
      rd_byte = p0_rd;
    end
    else if (idx == IDX_P1_OUT_LATCH)
    begin
      rd_byte = p1_rd;
    end
    else if (idx == IDX_P1_PIN_MODE)
    begin
      rd_byte = pmode_q;
    end
    else if (idx == IDX_WAVE_MODE)
    begin
      rd_byte = wmode_q;
    end
    else if (idx == IDX_INT_STATUS)
    begin
      rd_byte = {4'h0, ist_q};
    end
    else if (idx == IDX_INT_MASK)
    begin
      rd_byte = {4'h0, imsk_q};
    end
    else
    begin
      rd_byte = 8'h00;
    end
  end

  // Bus handshake: one wait cycle, answer on the second edge, write lands there too
  always_comb
  begin
    bus_d   = bus_q;
    wait_d  = 1'b1;
    rdata_d = rdata_q;
    case (bus_q)
      BUS_IDLE:
      begin
        if (AVS_READ || AVS_WRITE)
        begin
          bus_d   = BUS_ACK;
          wait_d  = 1'b0;
          rdata_d = AVS_READ ? {24'h000000, rd_byte} : 32'h00000000;
        end
      end
      BUS_ACK:
      begin
        bus_d = BUS_IDLE;
      end
      default:
      begin
        bus_d = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      bus_q   <= BUS_IDLE;
      wait_q  <= 1'b1;
      rdata_q <= 32'h00000000;
    end
    else
    begin
      bus_q   <= bus_d;
      wait_q  <= wait_d;
      rdata_q <= rdata_d;
    end
  end

  // Register writes; reserved bits forced so they never change
  always_comb
  begin
    asel_d  = asel_q;
    pmode_d = pmode_q;
    dir_d   = dir_q;
    latch_d = latch_q;
    wmode_d = wmode_q;
    imsk_d  = imsk_q;
    if (wr_lo)
    begin
      if (idx == IDX_P0_ANALOG)
      begin
        asel_d = wb;
      end
      else if (idx == IDX_P1_PIN_MODE)
      begin
        pmode_d = wb | P1_MODE_RSV;
      end
      else if (idx == IDX_P1_DIR_CTRL)
      begin
        dir_d = wb | P1_DIR_RSV;
      end
      else if (idx == IDX_P1_OUT_LATCH)
      begin
        latch_d = (wb & P1_GEN_PINS) | P1_MODE_RSV;
      end
      else if (idx == IDX_WAVE_MODE)
      begin
        wmode_d = wb | WAVE_MODE_RSV;
      end
      else if (idx == IDX_INT_MASK)
      begin
        imsk_d = wb[3:0];
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      asel_q  <= RST_P0_ANALOG;
      pmode_q <= RST_P1_MODE;
      dir_q   <= RST_P1_DIR;
      latch_q <= RST_P1_LATCH;
      wmode_q <= RST_WAVE_MODE;
      imsk_q <= 4'h0;
    end
    else
    begin
      asel_q  <= asel_d;
      pmode_q <= pmode_d;
      dir_q   <= dir_d;
      latch_q <= latch_d;
      wmode_q <= wmode_d;
      imsk_q <= imsk_d;
    end
  end

  // Port 0: level captured only when active, so sleep keeps the last value
  always_comb
  begin
    // buffers off outside active and sleep
    p0_lvl_d = (PWR_MODE == PWR_ACTIVE) ? (P0_IN & ~asel_q) : p0_lvl_q;
    // digital buffer or converter channel per pin
    p0_en_d  = pins_live ? ~asel_q : 8'h00;
    an_d     = pins_live ? asel_q : 8'h00;
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      p0_lvl_q <= 8'h00;
      p0_en_q  <= 8'h00;
      an_q     <= 8'h00;
    end
    else
    begin
      p0_lvl_q <= p0_lvl_d;
      p0_en_q  <= p0_en_d;
      an_q     <= an_d;
    end
  end

  // canceller forced off in low-power modes
  assign nc_on = pmode_q[NC_BIT] && !low_power;

  ipf_noise_cancel #(
    .DIV (NC_DIV)
  ) ipf_noise_cancel_inst (
    .CORE_CLK  (CORE_CLK),
    .RST_B     (RST_B),
    .nc_enable (nc_on),
    .level_in  (xirq_raw[0]),
    .level_out (int0_filt)
  );

  // Interrupt routing per pin; a line not selected idles high
  genvar g;
  generate
    for (g = 0; g < NUM_IRQ; g++)
    begin : g_irq
      // mode bit routes the pin to its interrupt
      assign xirq_raw[g] = pmode_q[IRQ_PIN[g]] ? P1_IN[IRQ_PIN[g]] : 1'b1;
    end
  endgenerate

  assign wave_sel = !pmode_q[EXT_INT5_BIT] && wmode_q[WAVE_SEL];

  // Pad drive, count input and interrupt lines
  always_comb
  begin
    // direction bit drives the general pins
    drv_d.oe   = dir_q & P1_GEN_PINS & ~(pmode_q & P1_GEN_PINS);
    drv_d.dout = latch_q & P1_GEN_PINS;
    // bit 5 clear leaves pin for I/O or waveform
    if (wave_sel)
    begin
      drv_d.oe[EXT_INT5_BIT]   = 1'b1;
      drv_d.dout[EXT_INT5_BIT] = wmode_q[WAVE_ON] && TIMER_WAVE_IN;
    end
    // bit 6 routes the input pin to the counter
    cnt_d  = pmode_q[EVENT_BIT] ? P1_IN[EVENT_BIT] : 1'b1;
    xirq_d = {xirq_raw[3:1], int0_filt};
  end

  // Falling edge of a routed active-low line is an interrupt event
  assign xirq_evt = xirq_q & ~xirq_d;

  // Status bits: a new event wins over a same-cycle write-one clear
  always_comb
  begin
    ist_d = ist_q;
    if (wr_lo && (idx == IDX_INT_STATUS))
    begin
      ist_d = ist_q & ~wb[3:0];
    end
    ist_d = ist_d | xirq_evt;
    irq_d = |(ist_d & imsk_d);
  end

  always_ff @(posedge CORE_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      drv_q  <= '0;
      cnt_q  <= 1'b1;
      xirq_q <= 4'hf;
      ist_q  <= 4'h0;
      irq_q  <= 1'b0;
    end
    else
    begin
      drv_q  <= drv_d;
      cnt_q  <= cnt_d;
      xirq_q <= xirq_d;
      ist_q  <= ist_d;
      irq_q  <= irq_d;
    end
  end

  // four driven pins, two input-only pins never driven
  assign P1_OUT          = drv_q.dout;
  assign P1_OE           = drv_q.oe;
  assign P0_BUF_EN       = p0_en_q;
  assign ANALOG_CH_EN    = an_q;
  assign COUNT_IN_N      = cnt_q;
  assign EXT_IRQ_N       = xirq_q;
  assign IRQ             = irq_q;
  assign AVS_READDATA    = rdata_q;
  assign AVS_WAITREQUEST = wait_q;

  localparam int ACK_MAX = 2;

  p0_read_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (bus_q == BUS_IDLE) && AVS_READ && (idx == IDX_P0_LEVELS) |=> (AVS_READDATA[7:0] == $past(p0_rd))
      && ((AVS_READDATA[7:0] & $past(asel_q)) == $past(asel_q)))
    else $error("port-0 read does not show level or analog ones");

  p0_hiz_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    low_power |=> (P0_BUF_EN == 8'h00) && (ANALOG_CH_EN == 8'h00))
    else $error("port-0 buffers enabled in a low-power mode");

  p0_hold_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (PWR_MODE == PWR_SLEEP) |=> $stable(p0_lvl_q))
    else $error("port-0 level changed in sleep");

  mode_rsv_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    pmode_q[3:2] == 2'b11)
    else $error("mode register reserved bits not one");

  nc_off_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    low_power && pmode_q[0] ##1 low_power |=> (EXT_IRQ_N[0] == $past(P1_IN[0], 2)))
    else $error("interrupt 0 filtered in a low-power mode");

  count_route_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    !pmode_q[EVENT_BIT] |=> COUNT_IN_N)
    else $error("count input active while pin is general input");

  irq_route_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    pmode_q[EXT_INT4_BIT] && !P1_IN[EXT_INT4_BIT] |=> !EXT_IRQ_N[2] && !P1_OE[EXT_INT4_BIT])
    else $error("interrupt 4 pin not routed");

  dir_drive_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    dir_q[0] && !pmode_q[0] |=> P1_OE[0] && (P1_OUT[0] == $past(latch_q[0])))
    else $error("output pin not driven from latch");

  wave_route_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    pmode_q[EXT_INT5_BIT] |=> !P1_OE[EXT_INT5_BIT])
    else $error("interrupt 5 pin is driven");

  bus_ack_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    (AVS_READ || AVS_WRITE) |-> ##[0:ACK_MAX] !AVS_WAITREQUEST)
    else $error("bus request not answered in time");

  irq_out_a: assert property (@(posedge CORE_CLK) disable iff (!RST_B)
    xirq_evt[1] && imsk_q[1] |=> IRQ && ist_q[1])
    else $error("unmasked event did not raise the interrupt");

  rd_c: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
    AVS_READ && !AVS_WAITREQUEST && (idx == IDX_P1_OUT_LATCH));
  sleep_c: cover property (@(posedge CORE_CLK) disable iff (!RST_B)
    (PWR_MODE == PWR_ACTIVE) ##1 (PWR_MODE == PWR_SLEEP));
  irq_c: cover property (@(posedge CORE_CLK) disable iff (!RST_B) $rose(IRQ));
  wave_c: cover property (@(posedge CORE_CLK) disable iff (!RST_B) wave_sel && P1_OUT[EXT_INT5_BIT]);

endmodule
`default_nettype wire

/* bench/ipf_board_model.sv */
`timescale 1ns/1ps
`default_nettype none
module ipf_board_model (
  input  wire logic [7:0] board_level,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  output var  logic [7:0] pad_in
);
  // Pad level: the device wins where it drives, else the board's own level
  // driven pads
  always_comb
  begin
    pad_in = (pad_oe & pad_out) | (~pad_oe & board_level);
  end
endmodule
`default_nettype wire

/* bench/input_port_and_pin_function_select_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, gt) \
  compares++; \
  if ((gt) !== (ex)) \
  begin \
    fails++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); \
  end
module input_port_and_pin_function_select_bench;
  import ipf_pkg::*;
  logic        core_clk;
  logic        rst_b;
  logic [17:0] avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  ipf_pwr_e    pwr_mode;
  logic [7:0]  p0_in;
  logic [7:0]  p0_buf_en;
  logic [7:0]  analog_ch_en;
  logic [7:0]  p1_in;
  logic [7:0]  p1_out;
  logic [7:0]  p1_oe;
  logic [7:0]  board;
  logic        timer_wave_in;
  logic        count_in_n;
  logic [3:0]  ext_irq_n;
  logic        irq;
  logic [7:0]  seed;
  int          fails;
  int          compares;

  ipf_port_top #(.NC_DIV(4)) ipf_port_top_inst (
    .CORE_CLK(core_clk), .RST_B(rst_b), .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
    .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata), .AVS_BYTEENABLE(avs_byteenable),
    .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest), .PWR_MODE(pwr_mode),
    .P0_IN(p0_in), .P0_BUF_EN(p0_buf_en), .ANALOG_CH_EN(analog_ch_en), .P1_IN(p1_in),
    .P1_OUT(p1_out), .P1_OE(p1_oe), .TIMER_WAVE_IN(timer_wave_in), .COUNT_IN_N(count_in_n),
    .EXT_IRQ_N(ext_irq_n), .IRQ(irq)
  );

  ipf_board_model ipf_board_model_inst (
    .board_level(board), .pad_out(p1_out), .pad_oe(p1_oe), .pad_in(p1_in)
  );

  // Clock at 100 MHz
  initial
  begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Pseudo-random bytes, repeatable from the fixed start value
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  // Expected port-1 read: latch where driven, pad elsewhere, spare bits one
  function automatic logic [7:0] exp_p1(input logic [7:0] d, input logic [7:0] l, input logic [7:0] b);
    return (((d & l) | (~d & b)) & P1_GEN_PINS) | P1_MODE_RSV | (b & P1_IN_ONLY);
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // One bus access; holds the request until waitrequest is seen low
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd,
                     input logic [3:0] be, output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge core_clk);
    avs_address    <= {idx, 2'b00};
    avs_write      <= wr;
    avs_read       <= ~wr;
    avs_writedata  <= {24'h000000, wd};
    avs_byteenable <= be;
    do
    begin
      @(posedge core_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    if (n >= 50)
    begin
      fails++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [15:0] idx, input logic [7:0] v);
    logic [7:0] dummy;
    bus(1'b1, idx, v, 4'hf, dummy);
  endtask

  task automatic rd_chk(input string nm, input logic [15:0] idx, input logic [7:0] ex);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, 4'hf, v);
    `CHK(nm, ex, v)
  endtask

  // Wait for one extended interrupt line to reach a level, bounded
  task automatic wait_ext_interrupt_0(input logic lvl, input int lim, output int n);
    n = 0;
    while (ext_irq_n[0] !== lvl && n < lim)
    begin
      @(posedge core_clk);
      n++;
    end
  endtask

  initial
  begin : main
    logic [7:0] d;
    logic [7:0] l;
    logic [7:0] a;
    int         n;
    int         pin [4] = '{0, 1, 4, 5};
    fails = 0;
    compares = 0;
    seed = 8'd80;
    rst_b = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
    pwr_mode = PWR_ACTIVE;
    p0_in = 8'h00;
    board = 8'hff;
    timer_wave_in = 1'b0;
    tick(10);
    rst_b <= 1'b1;
    // Reset values and refused accesses
    rd_chk("pin mode reset", IDX_P1_PIN_MODE, 8'h0c);
    rd_chk("wave mode reset", IDX_WAVE_MODE, 8'h0f);
    rd_chk("unmapped", 16'h0000, 8'h00);
    rd_chk("port1 after reset", IDX_P1_OUT_LATCH, 8'hff);
    bus(1'b1, IDX_P1_PIN_MODE, 8'hf3, 4'h0, d);
    rd_chk("no byte enable", IDX_P1_PIN_MODE, 8'h0c);
    // Spare mode bits stay one whatever is written
    for (int i = 0; i < 8; i++)
    begin
      seed = lfsr_next(seed);
      wr(IDX_P1_PIN_MODE, seed);
      rd_chk("pin mode", IDX_P1_PIN_MODE, seed | 8'h0c);
    end
    wr(IDX_P1_PIN_MODE, 8'h00);
    // Port-1 direction, latch and pad reads
    for (int i = 0; i < 8; i++)
    begin
      d = lfsr_next(seed);
      l = lfsr_next(d);
      seed = lfsr_next(l);
      board <= seed;
      wr(IDX_P1_DIR_CTRL, d);
      wr(IDX_P1_OUT_LATCH, l);
      tick(3);
      `CHK("pad enable", d & 8'h33, p1_oe)
      `CHK("pad data", l & d & 8'h33, p1_out & p1_oe)
      rd_chk("port1 read", IDX_P1_OUT_LATCH, exp_p1(d, l, seed));
    end
    // Port-0 digital or analog use
    for (int i = 0; i < 8; i++)
    begin
      a = lfsr_next(seed);
      seed = lfsr_next(a);
      p0_in <= seed;
      wr(IDX_P0_ANALOG, a);
      tick(3);
      `CHK("analog enables", a, analog_ch_en)
      `CHK("buffer enables", ~a, p0_buf_en)
      rd_chk("port0 read", IDX_P0_LEVELS, seed | a);
    end
    pwr_mode <= PWR_SLEEP;
    p0_in <= ~seed;
    tick(3);
    `CHK("sleep buffers", ~a, p0_buf_en)
    rd_chk("sleep level", IDX_P0_LEVELS, seed | a);
    pwr_mode <= PWR_STANDBY;
    tick(3);
    `CHK("standby hi-z", 16'h0000, {p0_buf_en, analog_ch_en})
    pwr_mode <= PWR_WATCH;
    tick(3);
    `CHK("watch hi-z", 16'h0000, {p0_buf_en, analog_ch_en})
    pwr_mode <= PWR_SUBACTIVE;
    tick(3);
    `CHK("subactive hi-z", 16'h0000, {p0_buf_en, analog_ch_en})
    pwr_mode <= PWR_ACTIVE;
    // Waveform output on shared pin 5
    wr(IDX_P1_DIR_CTRL, 8'h00);
    wr(IDX_WAVE_MODE, 8'h80);
    tick(3);
    `CHK("wave off low", 2'b10, {p1_oe[5], p1_out[5]})
    timer_wave_in <= 1'b1;
    wr(IDX_WAVE_MODE, 8'hc0);
    tick(3);
    `CHK("wave on", 2'b11, {p1_oe[5], p1_out[5]})
    rd_chk("wave mode", IDX_WAVE_MODE, 8'hcf);
    wr(IDX_WAVE_MODE, 8'h00);
    // Count input routing; count line follows the level of pin 6 while mode bit 6 is set
    wr(IDX_P1_PIN_MODE, 8'h40);
    board <= 8'hbf;
    tick(3);
    `CHK("count low", 1'b0, count_in_n)
    board <= 8'hff;
    tick(3);
    `CHK("count high", 1'b1, count_in_n)
    // Interrupts: masked before the mode change, stale requests cleared after
    // software order
    wr(IDX_INT_MASK, 8'h00);
    wr(IDX_P1_DIR_CTRL, 8'h33);
    wr(IDX_P1_PIN_MODE, 8'h33);
    tick(1);
    wr(IDX_INT_STATUS, 8'h0f);
    wr(IDX_INT_MASK, 8'h0f);
    tick(3);
    `CHK("irq pins undriven", 8'h00, p1_oe)
    `CHK("count idle", 1'b1, count_in_n)
    for (int i = 0; i < 4; i++)
    begin
      board <= 8'hff & ~(8'h01 << pin[i]);
      tick(4);
      `CHK("irq line", 4'hf & ~(4'h1 << i), ext_irq_n)
      `CHK("irq out", 1'b1, irq)
      rd_chk("status", IDX_INT_STATUS, 8'h01 << i);
      wr(IDX_INT_MASK, 8'h0f & ~(8'h01 << i));
      tick(2);
      `CHK("irq masked", 1'b0, irq)
      board <= 8'hff;
      wr(IDX_INT_STATUS, 8'h01 << i);
      wr(IDX_INT_MASK, 8'h0f);
      tick(2);
      `CHK("irq cleared", 1'b0, irq)
    end
    // Noise canceller on interrupt 0, sampled every 4 states here
    wr(IDX_P1_PIN_MODE, 8'h81);
    tick(12);
    board <= 8'hfe;
    tick(1);
    board <= 8'hff;
    wait_ext_interrupt_0(1'b0, 16, n);
    `CHK("glitch filtered", 16, n)
    board <= 8'hfe;
    wait_ext_interrupt_0(1'b0, 20, n);
    `CHK("steady passes", 1'b1, n >= 4 && n < 20)
    pwr_mode <= PWR_STANDBY;
    tick(1);
    board <= 8'hff;
    wait_ext_interrupt_0(1'b1, 20, n);
    `CHK("standby unfiltered", 1'b1, n <= 3)
    pwr_mode <= PWR_ACTIVE;
    tick(2);
    end_of_test();
  end

  // Bound on the whole run
  initial
  begin
    #900000;
    fails++;
    end_of_test();
  end
endmodule
`default_nettype wire
